// ---- pmt_pkg.sv ----
// Package with register map, field layout and reset values for the period match timer
package pmt_pkg;
	// ======================================================================
	// Register indices (printed offsets are not all multiples of four)
	localparam logic [7:0]  PMT_IDX_COUNT   = 8'h11;
	localparam logic [7:0]  PMT_IDX_CONTROL = 8'h12;
	localparam logic [7:0]  PMT_IDX_PERIOD  = 8'h92;
	localparam logic [7:0]  PMT_IDX_FLAG    = 8'h0C;
	localparam logic [7:0]  PMT_IDX_ENABLE  = 8'h8C;
	localparam logic [11:0] PMT_ADDR_COUNT   = {2'h0, PMT_IDX_COUNT, 2'h0};
	localparam logic [11:0] PMT_ADDR_CONTROL = {2'h0, PMT_IDX_CONTROL, 2'h0};
	localparam logic [11:0] PMT_ADDR_PERIOD  = {2'h0, PMT_IDX_PERIOD, 2'h0};
	localparam logic [11:0] PMT_ADDR_FLAG    = {2'h0, PMT_IDX_FLAG, 2'h0};
	localparam logic [11:0] PMT_ADDR_ENABLE  = {2'h0, PMT_IDX_ENABLE, 2'h0};
	// ======================================================================
	// Reset values and field positions
	localparam logic [7:0] PMT_COUNT_RST   = 8'h00;
	localparam logic [6:0] PMT_CONTROL_RST = 7'h00;
	localparam logic [7:0] PMT_PERIOD_RST  = 8'hFF;
	localparam int PMT_RUN_BIT   = 2;
	localparam int PMT_PS_LSB    = 3;
	localparam int PMT_FLAG_BIT  = 1;
	localparam int PMT_FOSC_DIV  = 4;
	localparam logic [1:0] PMT_PRE_DIV1  = 2'h0;
	localparam logic [1:0] PMT_PRE_DIV4  = 2'h1;
	localparam logic [3:0] PMT_PRE_MAX1  = 4'h0;
	localparam logic [3:0] PMT_PRE_MAX4  = 4'h3;
	localparam logic [3:0] PMT_PRE_MAX16 = 4'hF;
	localparam logic [1:0] PMT_Q_LAST    = 2'h3;
endpackage

// ---- pmt_tick_if.sv ----
// Interface carrying scaler control and tick signals between the timer modules
`timescale 1ns/10ps
interface pmt_tick_if;
	logic       clear;   // Scaler clear request
	logic [3:0] max;     // Terminal count of the divider
	logic       tick_in; // Incoming event
	logic       tick_out; // Divided event pulse
	modport ctl (output clear, output max, output tick_in, input tick_out);
	modport div (input clear, input max, input tick_in, output tick_out);
endinterface

// ---- pmt_divider.sv ----
// Event divider used as both prescaler and postscaler
`timescale 1ns/10ps
module pmt_divider
	import pmt_pkg::*;
(
	input  wire logic pclk,    // Clock
	input  wire logic presetn, // Async reset, active low
	pmt_tick_if.div   tk       // Divider control and ticks
);
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic       hit;
	// ======================================================================
	// Terminal count decode, pulse is combinational for zero latency
	assign hit         = tk.tick_in && (cnt_reg == tk.max);
	assign tk.tick_out = hit;
	assign cnt_next    = tk.clear ? 4'h0 : (hit ? 4'h0 : (tk.tick_in ? cnt_reg + 4'h1 : cnt_reg));
	// Counter state
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cnt_reg <= 4'h0;
		else
			cnt_reg <= cnt_next;
endmodule

// ---- pmt_top.sv ----
// Period match timer top level with APB register slave
// Functional notes
// - The count register is an 8-bit up-counter readable and writable by software with its own scalers.
// - The counter advances on the oscillator divided by four, passed through the prescaler.
// - Control bits 1:0 choose prescale 1, 4, or 16 for codes 00, 01 and 1x.
// - The count rises from zero to the period value and returns to zero on the next increment.
// - The period register is 8-bit read/write and loads FFh on reset.
// - Reset clears the count register.
// - Match pulses pass a 4-bit postscaler whose output sets the match flag in flag bit 1.
// - Control bits 6:3 set the postscale ratio to field value plus one.
// - Control bit 2 runs the timer; when clear the counter stops.
// - Both scaler counters clear on count writes, control writes and reset.
// - A control write leaves the count unchanged.
// - The pre-postscaler match pulse goes out to the serial port as a shift clock source.
// - Control bit 7 reads as zero.
`timescale 1ns/10ps
module pmt_top
	import pmt_pkg::*;
(
	input  wire logic        pclk,          // APB clock, 200 MHz
	input  wire logic        presetn,       // Async reset, active low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB enable
	input  wire logic        pwrite,        // APB direction
	input  wire logic [11:0] paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	input  wire logic [3:0]  pstrb,         // APB byte strobes
	output logic      [31:0] prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error
	output logic             ssp_shift_clk, // Match pulse for serial port
	output logic             irq_req        // Flag and enable request
);
	// ======================================================================
	// State
	logic [7:0]  count_reg;
	logic [7:0]  count_next;
	logic [6:0]  control_reg;
	logic [6:0]  control_next;
	logic [7:0]  period_reg;
	logic [7:0]  period_next;
	logic        flag_reg;
	logic        flag_next;
	logic        irq_en_reg;
	logic        irq_en_next;
	logic [1:0]  quarter_reg;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        ssp_reg;
	logic        irq_reg;

	pmt_tick_if pre_if ();
	pmt_tick_if post_if ();

	// ======================================================================
	// APB decode, zero-wait access phase
	logic access;
	logic wr_en;
	logic rd_en;
	logic hit_count;
	logic hit_control;
	logic hit_period;
	logic hit_flag;
	logic hit_enable;
	logic mapped;
	logic wr_count;
	logic wr_control;
	logic wr_period;
	logic wr_flag;
	logic wr_enable;
	logic lane0;

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_addr);
		addr_is = (a == ref_addr);
	endfunction

	// Any register of the map; every other address answers with an error
	function automatic logic addr_is_any(input logic [11:0] a);
		addr_is_any = addr_is(a, PMT_ADDR_COUNT) || addr_is(a, PMT_ADDR_CONTROL) ||
		              addr_is(a, PMT_ADDR_PERIOD) || addr_is(a, PMT_ADDR_FLAG) ||
		              addr_is(a, PMT_ADDR_ENABLE);
	endfunction

	assign access      = psel && penable;
	assign wr_en       = access && pwrite;
	// Reads are fetched in setup so that the registered data stands beside ready
	assign rd_en       = psel && !penable && !pwrite;
	assign hit_count   = addr_is(paddr, PMT_ADDR_COUNT);
	assign hit_control = addr_is(paddr, PMT_ADDR_CONTROL);
	assign hit_period  = addr_is(paddr, PMT_ADDR_PERIOD);
	assign hit_flag    = addr_is(paddr, PMT_ADDR_FLAG);
	assign hit_enable  = addr_is(paddr, PMT_ADDR_ENABLE);
	assign mapped      = addr_is_any(paddr);
	// Only lane 0 holds data; a write with lane 0 off changes nothing
	assign lane0       = pstrb[0];
	assign wr_count    = wr_en && hit_count && lane0;
	assign wr_control  = wr_en && hit_control && lane0;
	assign wr_period   = wr_en && hit_period && lane0;
	assign wr_flag     = wr_en && hit_flag && lane0;
	assign wr_enable   = wr_en && hit_enable && lane0;

	// ======================================================================
	// Instruction clock: one enable every fourth pclk
	logic instr_tick;
	logic run;
	logic [1:0] pre_sel;
	assign instr_tick = (quarter_reg == PMT_Q_LAST);
	assign run        = control_reg[PMT_RUN_BIT];
	assign pre_sel    = control_reg[1:0];

	// ======================================================================
	// Prescaler hookup
	assign pre_if.clear   = wr_count || wr_control;
	assign pre_if.tick_in = instr_tick && run;
	// Code 1x means divide by 16
	assign pre_if.max     = (pre_sel == PMT_PRE_DIV1) ? PMT_PRE_MAX1 :
	                        (pre_sel == PMT_PRE_DIV4) ? PMT_PRE_MAX4 : PMT_PRE_MAX16;

	pmt_divider u_pre
	(
		.pclk    (pclk),
		.presetn (presetn),
		.tk      (pre_if.div)
	);

	// ======================================================================
	// Period compare; a software count write overrides the increment
	logic inc;
	logic match;
	assign inc   = pre_if.tick_out && !wr_count;
	assign match = inc && (count_reg == period_reg);
	assign count_next = wr_count ? pwdata[7:0] :
	                    (match ? PMT_COUNT_RST : (inc ? count_reg + 8'h01 : count_reg));

	// ======================================================================
	// Postscaler hookup
	assign post_if.clear   = wr_count || wr_control;
	assign post_if.tick_in = match;
	assign post_if.max     = control_reg[PMT_PS_LSB +: 4];

	pmt_divider u_post
	(
		.pclk    (pclk),
		.presetn (presetn),
		.tk      (post_if.div)
	);

	// ======================================================================
	// Register next values; hardware set wins over a software clear
	assign control_next = wr_control ? pwdata[6:0] : control_reg;
	assign period_next  = wr_period ? pwdata[7:0] : period_reg;
	assign flag_next    = post_if.tick_out ? 1'b1 :
	                      (wr_flag ? pwdata[PMT_FLAG_BIT] : flag_reg);
	assign irq_en_next  = wr_enable ? pwdata[PMT_FLAG_BIT] : irq_en_reg;

	// Read mux; unimplemented bits read zero
	always_comb
	begin
		prdata_next = 32'h0000_0000;
		if (rd_en)
		begin
			if (hit_count)
				prdata_next = {24'h00_0000, count_reg};
			else if (hit_control)
				prdata_next = {25'h000_0000, control_reg};
			else if (hit_period)
				prdata_next = {24'h00_0000, period_reg};
			else if (hit_flag)
				prdata_next = {30'h0000_0000, flag_reg, 1'b0};
			else if (hit_enable)
				prdata_next = {30'h0000_0000, irq_en_reg, 1'b0};
		end
	end

	// ======================================================================
	// Count and control registers
	// Count register; a software write beats a same-cycle increment
	// so the register holds the value just written on the following cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			count_reg <= PMT_COUNT_RST;
		else
			count_reg <= count_next;

	// Control register; bit 7 has no storage at all
	// Its write also pulses the scaler clears, but never the count
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			control_reg <= PMT_CONTROL_RST;
		else
			control_reg <= control_next;

	// ======================================================================
	// Period register
	// Loaded with all ones so a fresh timer runs the longest period
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			period_reg <= PMT_PERIOD_RST;
		else
			period_reg <= period_next;

	// ======================================================================
	// Flag and enable registers
	// Match flag; only software takes it down again
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			flag_reg <= 1'b0;
		else
			flag_reg <= flag_next;

	// Request enable
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_en_reg <= 1'b0;
		else
			irq_en_reg <= irq_en_next;

	// ======================================================================
	// Instruction clock phase
	// Free-running, never cleared by writes, so ticks stay evenly spaced;
	// the price is up to three pclk of jitter on the first step after a write
	logic [1:0] quarter_next;
	assign quarter_next = quarter_reg + 2'h1;

	// Phase counter
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			quarter_reg <= 2'h0;
		else
			quarter_reg <= quarter_next;

	// ======================================================================
	// Bus response
	// Ready rises one cycle after setup, so every access phase lasts one cycle
	logic pready_next;
	logic pslverr_next;
	assign pready_next  = psel && !penable;
	assign pslverr_next = psel && !penable && !mapped;

	// Read data; zero outside the cycle in which ready stands
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else
			prdata_reg <= prdata_next;

	// Ready
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			pready_reg <= 1'b0;
		else
			pready_reg <= pready_next;

	// Error for unmapped addresses, alongside ready
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			pslverr_reg <= 1'b0;
		else
			pslverr_reg <= pslverr_next;

	// ======================================================================
	// Event outputs
	// Registered so the serial port sees a clean one-cycle pulse
	logic ssp_next;
	logic irq_next;
	assign ssp_next = match;
	// Request follows the next flag and enable, so it moves at the same edge as they do
	assign irq_next = flag_next && irq_en_next;

	// Shift clock pulse
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ssp_reg <= 1'b0;
		else
			ssp_reg <= ssp_next;

	// Request level
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_reg <= 1'b0;
		else
			irq_reg <= irq_next;

	// ======================================================================
	// Output ports

	assign prdata        = prdata_reg;
	assign pready        = pready_reg;
	assign pslverr       = pslverr_reg;
	assign ssp_shift_clk = ssp_reg;
	assign irq_req       = irq_reg;
endmodule

// ---- pmt_assertions.sv ----
// Checker holding the port-level assertions of the period match timer
`timescale 1ns/10ps
module pmt_assertions
	import pmt_pkg::*;
(
	input wire logic        pclk,          // Clock
	input wire logic        presetn,       // Reset, low
	input wire logic        psel,          // Select
	input wire logic        penable,       // Enable
	input wire logic        pwrite,        // Direction
	input wire logic [11:0] paddr,         // Address
	input wire logic [31:0] pwdata,        // Write data
	input wire logic [3:0]  pstrb,         // Strobes
	input wire logic [31:0] prdata,        // Read data
	input wire logic        pready,        // Ready
	input wire logic        pslverr,       // Error
	input wire logic        ssp_shift_clk, // Match pulse
	input wire logic        irq_req        // Request
);
	// Write decode; run and enable live inside, so they are mirrored
	wire wr = psel && penable && pready && pwrite && pstrb[0];
	wire fe = wr && (paddr == PMT_ADDR_FLAG || paddr == PMT_ADDR_ENABLE);
	wire mapped = paddr inside {PMT_ADDR_COUNT, PMT_ADDR_CONTROL, PMT_ADDR_PERIOD, PMT_ADDR_FLAG, PMT_ADDR_ENABLE};
	logic       run_reg, en_reg, fe_reg;
	logic [1:0] stop_reg;
	// Stop count saturates at 3, leaving room for a pulse already in flight
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{run_reg, en_reg, fe_reg, stop_reg} <= 5'h00;
		else
		begin
			if (wr && paddr == PMT_ADDR_CONTROL)
				run_reg <= pwdata[PMT_RUN_BIT];
			if (wr && paddr == PMT_ADDR_ENABLE)
				en_reg <= pwdata[PMT_FLAG_BIT];
			fe_reg <= fe;
			stop_reg <= run_reg ? 2'h0 : stop_reg + {1'b0, stop_reg != 2'h3};
		end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ======================================================================
	// Assertions
	a_ready_setup: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not one cycle after setup");
	a_unmapped_err: assert property (pready && !mapped |-> pslverr)
		else $error("unmapped access without error");
	a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data or error outside access");
	a_ctl_top_zero: assert property (pready && !pwrite && paddr == PMT_ADDR_CONTROL |-> prdata[31:7] == 25'h0)
		else $error("control upper bits not zero");
	a_pulse_single: assert property (ssp_shift_clk |=> !ssp_shift_clk)
		else $error("match pulse longer than one cycle");
	a_stop_quiet: assert property (stop_reg == 2'h3 |-> !ssp_shift_clk)
		else $error("match pulse while stopped");
	a_irq_masked: assert property (!en_reg && !$past(en_reg) |-> !irq_req)
		else $error("request while disabled");
	a_flag_holds: assert property (irq_req && !fe && !fe_reg && !$past(fe_reg) |=> irq_req)
		else $error("request dropped without a clear");
	c_pulse: cover property (ssp_shift_clk);
	c_irq: cover property ($rose(irq_req));
	c_err: cover property (pslverr);
endmodule
bind pmt_top pmt_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .ssp_shift_clk(ssp_shift_clk), .irq_req(irq_req));

// ---- tb.sv ----
// Self-checking testbench of the period match timer
`timescale 1ns/10ps
module tb
	import pmt_pkg::*;
;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic x;} pmt_row_t;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, pslverr, ssp_shift_clk, irq_req, er;
	int          n_fail = 0, checks_done = 0, g, n, i, dv[4] = '{1, 4, 16, 16}, ps[3] = '{0, 3, 15};
	pmt_row_t rows[12] = '{'{0, PMT_ADDR_COUNT, 0, 32'h0, 0}, '{0, PMT_ADDR_CONTROL, 0, 32'h0, 0},
		'{0, PMT_ADDR_PERIOD, 0, 32'hFF, 0}, '{0, PMT_ADDR_FLAG, 0, 32'h0, 0},
		'{0, PMT_ADDR_ENABLE, 0, 32'h0, 0}, '{1, 12'h100, 32'hFF, 32'h0, 1}, '{0, 12'h100, 0, 32'h0, 1},
		'{1, PMT_ADDR_CONTROL, 32'hFFFFFFFF, 0, 0}, '{0, PMT_ADDR_CONTROL, 0, 32'h7F, 0},
		'{1, PMT_ADDR_CONTROL, 0, 0, 0}, '{1, PMT_ADDR_PERIOD, 32'hA5, 0, 0}, '{0, PMT_ADDR_PERIOD, 0, 32'hA5, 0}};
	pmt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ssp_shift_clk(ssp_shift_clk), .irq_req(irq_req));
	// ======================================================================
	// Clock, watchdog and shared tasks
	initial
		forever #2.5 pclk = ~pclk;
	initial
	begin
		#200000;
		n_fail++;
		report_and_stop;
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Request held until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// The second gap is whole; the first may straddle a reconfiguration
	task gap;
		for (int k = 0; k < 2; k++)
		begin
			for (n = 0; ssp_shift_clk !== 1'b1 && n < 2000; n++) @(posedge pclk);
			@(posedge pclk);
			for (g = 1; ssp_shift_clk !== 1'b1 && g < 2000; g++) @(posedge pclk);
		end
	endtask
	task report_and_stop;
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ======================================================================
	// Table, then hand-written cases
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[r])
		begin
			apb(rows[r].w, rows[r].a, rows[r].d);
			if (!rows[r].w) chk("rdata", rd, rows[r].e);
			chk("slverr", {31'h0, er}, {31'h0, rows[r].x});
		end
		pstrb <= 4'hE;
		apb(1, PMT_ADDR_PERIOD, 32'h33);
		pstrb <= 4'hF;
		apb(0, PMT_ADDR_PERIOD, 0);
		chk("strobe", rd, 32'hA5);
		apb(1, PMT_ADDR_PERIOD, 32'h2);
		apb(1, PMT_ADDR_COUNT, 32'h0);
		for (int c = 0; c < 4; c++)
		begin
			apb(1, PMT_ADDR_CONTROL, 32'h4 | c);
			gap;
			chk("gap", g, PMT_FOSC_DIV * dv[c] * 3);
		end
		apb(1, PMT_ADDR_PERIOD, 32'h1);
		apb(1, PMT_ADDR_ENABLE, 32'h2);
		foreach (ps[p])
		begin
			apb(1, PMT_ADDR_CONTROL, 32'h0);
			apb(1, PMT_ADDR_FLAG, 32'h0);
			apb(1, PMT_ADDR_COUNT, 32'h0);
			apb(1, PMT_ADDR_CONTROL, 32'h4 | (ps[p] << 3));
			g = 0;
			for (i = 0; i < 302 && (irq_req !== 1'b1 || i < 2); i++)
			begin
				@(posedge pclk);
				g += ssp_shift_clk;
				if (irq_req === 1'b1 && i < 300) i = 299;
			end
			chk("postscale", g, ps[p] + 1);
		end
		apb(1, PMT_ADDR_CONTROL, 32'h0);
		repeat (8) @(posedge pclk);
		chk("irq held", {31'h0, irq_req}, 32'h1);
		apb(0, PMT_ADDR_FLAG, 0);
		chk("flag", rd, 32'h2);
		for (i = 0; i < 3; i++)
		begin
			apb(1, i == 2 ? PMT_ADDR_FLAG : PMT_ADDR_ENABLE, i == 1 ? 32'h2 : 32'h0);
			repeat (2) @(posedge pclk);
			chk("irq gate", {31'h0, irq_req}, i == 1);
		end
		apb(1, PMT_ADDR_COUNT, 32'h5);
		apb(1, PMT_ADDR_CONTROL, 32'h78);
		repeat (20) @(posedge pclk);
		apb(0, PMT_ADDR_COUNT, 0);
		chk("count kept", rd, 32'h5);
		apb(1, PMT_ADDR_PERIOD, 32'h0);
		apb(1, PMT_ADDR_CONTROL, 32'h6);
		g = 0;
		for (i = 0; i < 6; i++)
		begin
			apb(1, i % 2 ? PMT_ADDR_CONTROL : PMT_ADDR_COUNT, i % 2 ? 32'h6 : 32'h0);
			repeat (40) @(posedge pclk) g += ssp_shift_clk;
		end
		chk("scaler clear", g, 0);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int r = 0; r < 3; r++)
		begin
			apb(0, rows[r].a, 0);
			chk("reset value", rd, rows[r].e);
		end
		report_and_stop;
	end
endmodule
